/* logic/oad_decoder.sv */
`timescale 1ns/100ps
module oad_decoder (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   start,
  input  wire logic [15:0]            start_pc,
  input  wire logic [7:0]             index_first,
  input  wire logic [7:0]             index_second,
  input  wire oad_pkg::oad_op_class_t op_class,
  input  wire logic                   wake_irq,
  input  wire logic [7:0]             mem_rdata,
  input  wire logic                   mem_ack,
  output logic                        mem_req,
  output logic [15:0]                 mem_addr,
  output logic [7:0]                  opcode,
  output logic                        busy,
  output logic                        done,
  output oad_pkg::oad_result_t        result,
  output logic                        osc_stop,
  output logic                        wait_for_interrupt_instr
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_CLASS = 3'b011,
    ST_OPND  = 3'b010,
    ST_PTR   = 3'b110,
    ST_CALC  = 3'b111,
    ST_DONE  = 3'b101
  } oad_state_t;

  oad_state_t          state;
  oad_state_t          next_state;
  oad_pkg::oad_plan_t  plan_now;
  oad_pkg::oad_plan_t  plan;
  oad_pkg::oad_op_class_t op_kept;
  logic                pre_second_idx;
  logic                pre_indirect;
  logic [15:0]         pc_cnt;
  logic [1:0]          cnt;
  logic [7:0]          opnd_hi;
  logic [7:0]          opnd_lo;
  logic [7:0]          ptr_hi;
  logic [7:0]          ptr_lo;
  logic [2:0]          len;
  logic [15:0]         ea_now;
  logic [15:0]         target_now;
  logic                rd_done;
  logic                last_byte;
  logic                need_read;
  logic [15:0]         read_addr;

  assign rd_done   = mem_req && mem_ack;
  assign last_byte = (state == ST_OPND) ? (cnt == plan.opnd_bytes - 2'h1)
                                        : (cnt == plan.ptr_bytes - 2'h1);
  assign need_read = !mem_req &&
    (state == ST_FETCH || state == ST_OPND || state == ST_PTR);

  // ****************************************************************
  // submodules
  // ****************************************************************
  oad_mode_plan u_plan (
    .op_class       (op_class),
    .pre_second_idx (pre_second_idx),
    .pre_indirect   (pre_indirect),
    .plan           (plan_now)
  );

  oad_addr_calc u_calc (
    .mode        (plan.mode),
    .opnd_hi     (opnd_hi),
    .opnd_lo     (opnd_lo),
    .ptr_hi      (ptr_hi),
    .ptr_lo      (ptr_lo),
    .index       (plan.use_second_idx ? index_second : index_first),
    .next_pc     (pc_cnt),
    .eff_addr    (ea_now),
    .jump_target (target_now)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (start && !osc_stop && !wait_for_interrupt_instr)
                  next_state = ST_FETCH;
      ST_FETCH: if (rd_done && !((mem_rdata == oad_pkg::OAD_PRE_SECOND_IDX ||
                    mem_rdata == oad_pkg::OAD_PRE_INDIRECT) &&
                    !pre_second_idx && !pre_indirect))
                  next_state = ST_CLASS;
      ST_CLASS: next_state = (plan_now.opnd_bytes != oad_pkg::OAD_CNT_ZERO)
                             ? ST_OPND : ST_CALC;
      ST_OPND:  if (rd_done && last_byte)
                  next_state = (plan.ptr_bytes != oad_pkg::OAD_CNT_ZERO)
                               ? ST_PTR : ST_CALC;
      ST_PTR:   if (rd_done && last_byte) next_state = ST_CALC;
      ST_CALC:  next_state = ST_DONE;
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) state <= ST_IDLE;
    else     state <= next_state;
  end

  // ****************************************************************
  // prebytes and opcode
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_second_idx <= 1'b0;
      pre_indirect   <= 1'b0;
      opcode         <= oad_pkg::OAD_BYTE_RESET;
    end else if (state == ST_IDLE) begin
      pre_second_idx <= 1'b0;
      pre_indirect   <= 1'b0;
    end else if (state == ST_FETCH && rd_done) begin
      if (!pre_second_idx && !pre_indirect &&
          mem_rdata == oad_pkg::OAD_PRE_SECOND_IDX)
        pre_second_idx <= 1'b1;
      else if (!pre_second_idx && !pre_indirect &&
               mem_rdata == oad_pkg::OAD_PRE_INDIRECT)
        pre_indirect <= 1'b1;
      else
        opcode <= mem_rdata;
    end
  end

  // ****************************************************************
  // memory port
  // ****************************************************************
  always_comb begin
    if (state == ST_PTR)
      read_addr = {oad_pkg::OAD_PAGE_ZERO, opnd_hi} +
                  {14'h0000, cnt};
    else
      read_addr = pc_cnt;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_req  <= 1'b0;
      mem_addr <= oad_pkg::OAD_ADDR_RESET;
    end else if (rd_done) begin
      mem_req  <= 1'b0;
    end else if (need_read) begin
      mem_req  <= 1'b1;
      mem_addr <= read_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      pc_cnt <= oad_pkg::OAD_ADDR_RESET;
    else if (state == ST_IDLE && start)
      pc_cnt <= start_pc;
    else if (rd_done && (state == ST_FETCH || state == ST_OPND))
      pc_cnt <= pc_cnt + 16'h0001;
  end

  // ****************************************************************
  // byte capture
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || state == ST_CLASS || (rd_done && last_byte))
      cnt <= oad_pkg::OAD_CNT_ZERO;
    else if (rd_done && (state == ST_OPND || state == ST_PTR))
      cnt <= cnt + 2'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opnd_hi <= oad_pkg::OAD_BYTE_RESET;
      opnd_lo <= oad_pkg::OAD_BYTE_RESET;
      ptr_hi  <= oad_pkg::OAD_BYTE_RESET;
      ptr_lo  <= oad_pkg::OAD_BYTE_RESET;
    end else if (rd_done && state == ST_OPND) begin
      if (cnt == oad_pkg::OAD_CNT_ZERO) opnd_hi <= mem_rdata;
      else                              opnd_lo <= mem_rdata;
    end else if (rd_done && state == ST_PTR) begin
      if (cnt == oad_pkg::OAD_CNT_ZERO) ptr_hi <= mem_rdata;
      else                              ptr_lo <= mem_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      plan    <= '0;
      op_kept <= '0;
      len     <= oad_pkg::OAD_OPCODE_LEN;
    end else if (state == ST_CLASS) begin
      plan    <= plan_now;
      op_kept <= op_class;
      len     <= oad_pkg::OAD_OPCODE_LEN + {1'b0, plan_now.opnd_bytes} +
                 {2'b00, pre_second_idx | pre_indirect};
    end
  end

  // ****************************************************************
  // results
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result <= '0;
    end else if (state == ST_CALC) begin
      result.mode           <= plan.mode;
      result.use_second_idx <= plan.use_second_idx;
      result.eff_addr       <= ea_now;
      result.literal        <= opnd_hi;
      result.jump_target    <= target_now;
      result.instr_len      <= len;
      result.rmw_long_err   <= plan.rmw_long_err;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      done <= (state == ST_CALC);
      busy <= (next_state != ST_IDLE);
    end
  end

  // ****************************************************************
  // low power requests
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_stop                 <= 1'b0;
      wait_for_interrupt_instr <= 1'b0;
    end else if (state == ST_CALC &&
                 plan.mode == oad_pkg::OAD_INHERENT) begin
      osc_stop                 <= op_kept.is_halt;
      wait_for_interrupt_instr <= op_kept.is_wfi;
    end else if (wake_irq) begin
      osc_stop                 <= 1'b0;
      wait_for_interrupt_instr <= 1'b0;
    end
  end

endmodule

/* inc/oad_pkg.sv */
// Functional notes
// - seventeen operand addressing modes in seven groups are decoded
// - short variants reach page zero, up to 1fe when indexed; long ones reach 64 Kbyte
// - read-modify-write memory instructions accept short variants only
// - inherent instruction is one byte; no operand bytes fetched
// - immediate instruction is two bytes; second byte is the literal
// - short direct fetches one byte used as page zero address
// - long direct fetches a word used as full address
// - indexed address is unsigned sum of selected index and offset
// - indexed without offset fetches nothing; index alone is address
// - short indexed adds offset byte to index, span 00 to 1fe
// - long indexed adds index to a fetched offset word
// - indirect: byte after opcode is page zero pointer address
// - short indirect reads a one-byte pointer from page zero
// - long indirect reads a two-byte pointer from page zero
// - relative target is next instruction address plus signed byte
// - halt stops oscillator; wait-for-interrupt waits for interrupt
// - prebyte 90 swaps first index register for the second
// - prebyte 92 turns direct forms and x indexed into indirect
package oad_pkg;

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [7:0]  OAD_PRE_SECOND_IDX = 8'h90;
  localparam logic [7:0]  OAD_PRE_INDIRECT   = 8'h92;
  localparam logic [7:0]  OAD_PAGE_ZERO      = 8'h00;
  localparam logic [15:0] OAD_ADDR_RESET     = 16'h0000;
  localparam logic [7:0]  OAD_BYTE_RESET     = 8'h00;
  localparam logic [2:0]  OAD_OPCODE_LEN     = 3'h1;
  localparam logic [1:0]  OAD_CNT_ZERO       = 2'h0;
  localparam logic [1:0]  OAD_CNT_ONE        = 2'h1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [4:0] {
    OAD_INHERENT    = 5'h00,
    OAD_IMMEDIATE   = 5'h01,
    OAD_DIR_SHORT   = 5'h02,
    OAD_DIR_LONG    = 5'h03,
    OAD_IDX_NONE    = 5'h04,
    OAD_IDX_SHORT   = 5'h05,
    OAD_IDX_LONG    = 5'h06,
    OAD_IND_SHORT   = 5'h07,
    OAD_IND_LONG    = 5'h08,
    OAD_IDXIND_S    = 5'h09,
    OAD_IDXIND_L    = 5'h0a,
    OAD_REL_DIR     = 5'h0b,
    OAD_REL_IND     = 5'h0c,
    OAD_BIT_DIR     = 5'h0d,
    OAD_BIT_IND     = 5'h0e,
    OAD_BITREL_DIR  = 5'h0f,
    OAD_BITREL_IND  = 5'h10
  } oad_mode_t;

  typedef struct packed {
    oad_mode_t mode;
    logic      is_rmw;
    logic      is_halt;
    logic      is_wfi;
  } oad_op_class_t;

  typedef struct packed {
    oad_mode_t   mode;
    logic        use_second_idx;
    logic [15:0] eff_addr;
    logic [7:0]  literal;
    logic [15:0] jump_target;
    logic [2:0]  instr_len;
    logic        rmw_long_err;
  } oad_result_t;

  typedef struct packed {
    oad_mode_t  mode;
    logic       use_second_idx;
    logic [1:0] opnd_bytes;
    logic [1:0] ptr_bytes;
    logic       rmw_long_err;
  } oad_plan_t;

endpackage

/* logic/oad_mode_plan.sv */
`timescale 1ns/100ps
module oad_mode_plan (
  input  wire oad_pkg::oad_op_class_t op_class,
  input  wire logic                   pre_second_idx,
  input  wire logic                   pre_indirect,
  output oad_pkg::oad_plan_t          plan
);

  // ****************************************************************
  // prebyte mapping and byte counts
  // ****************************************************************
  always_comb begin
    oad_pkg::oad_mode_t m;
    m = op_class.mode;
    if (pre_indirect) begin
      unique case (op_class.mode)
        oad_pkg::OAD_DIR_SHORT:  m = oad_pkg::OAD_IND_SHORT;
        oad_pkg::OAD_DIR_LONG:   m = oad_pkg::OAD_IND_LONG;
        oad_pkg::OAD_IDX_SHORT:  m = oad_pkg::OAD_IDXIND_S;
        oad_pkg::OAD_IDX_LONG:   m = oad_pkg::OAD_IDXIND_L;
        oad_pkg::OAD_REL_DIR:    m = oad_pkg::OAD_REL_IND;
        oad_pkg::OAD_BIT_DIR:    m = oad_pkg::OAD_BIT_IND;
        oad_pkg::OAD_BITREL_DIR: m = oad_pkg::OAD_BITREL_IND;
        default:                 m = op_class.mode;
      endcase
    end
    plan.mode           = m;
    plan.use_second_idx = pre_second_idx;
    plan.opnd_bytes     = 2'h0;
    plan.ptr_bytes      = 2'h0;
    unique case (m)
      oad_pkg::OAD_IMMEDIATE, oad_pkg::OAD_DIR_SHORT,
      oad_pkg::OAD_IDX_SHORT, oad_pkg::OAD_REL_DIR,
      oad_pkg::OAD_BIT_DIR:    plan.opnd_bytes = 2'h1;
      oad_pkg::OAD_DIR_LONG, oad_pkg::OAD_IDX_LONG,
      oad_pkg::OAD_BITREL_DIR: plan.opnd_bytes = 2'h2;
      oad_pkg::OAD_IND_SHORT, oad_pkg::OAD_IDXIND_S,
      oad_pkg::OAD_REL_IND, oad_pkg::OAD_BIT_IND: begin
        plan.opnd_bytes = 2'h1;
        plan.ptr_bytes  = 2'h1;
      end
      oad_pkg::OAD_IND_LONG, oad_pkg::OAD_IDXIND_L: begin
        plan.opnd_bytes = 2'h1;
        plan.ptr_bytes  = 2'h2;
      end
      oad_pkg::OAD_BITREL_IND: begin
        plan.opnd_bytes = 2'h2;
        plan.ptr_bytes  = 2'h1;
      end
      default: ;
    endcase
    // long variant on read-modify-write op
    plan.rmw_long_err = op_class.is_rmw &&
      (m == oad_pkg::OAD_DIR_LONG || m == oad_pkg::OAD_IDX_LONG ||
       m == oad_pkg::OAD_IND_LONG || m == oad_pkg::OAD_IDXIND_L);
  end

endmodule

/* logic/oad_addr_calc.sv */
`timescale 1ns/100ps
module oad_addr_calc (
  input  wire oad_pkg::oad_mode_t mode,
  input  wire logic [7:0]         opnd_hi,
  input  wire logic [7:0]         opnd_lo,
  input  wire logic [7:0]         ptr_hi,
  input  wire logic [7:0]         ptr_lo,
  input  wire logic [7:0]         index,
  input  wire logic [15:0]        next_pc,
  output logic [15:0]             eff_addr,
  output logic [15:0]             jump_target
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] page0(input logic [7:0] b);
    page0 = {oad_pkg::OAD_PAGE_ZERO, b};
  endfunction

  function automatic logic [15:0] add_idx(input logic [15:0] base,
                                          input logic [7:0]  idx);
    add_idx = base + {oad_pkg::OAD_PAGE_ZERO, idx};
  endfunction

  function automatic logic [15:0] rel(input logic [15:0] pc,
                                      input logic [7:0]  d);
    rel = pc + {{8{d[7]}}, d};
  endfunction

  // ****************************************************************
  // effective address and target
  // ****************************************************************
  always_comb begin
    eff_addr    = oad_pkg::OAD_ADDR_RESET;
    jump_target = oad_pkg::OAD_ADDR_RESET;
    unique case (mode)
      oad_pkg::OAD_DIR_SHORT, oad_pkg::OAD_BIT_DIR:
        eff_addr = page0(opnd_hi);
      oad_pkg::OAD_DIR_LONG:  eff_addr = {opnd_hi, opnd_lo};
      oad_pkg::OAD_IDX_NONE:  eff_addr = page0(index);
      oad_pkg::OAD_IDX_SHORT: eff_addr = add_idx(page0(opnd_hi), index);
      oad_pkg::OAD_IDX_LONG:
        eff_addr = add_idx({opnd_hi, opnd_lo}, index);
      oad_pkg::OAD_IND_SHORT, oad_pkg::OAD_BIT_IND:
        eff_addr = page0(ptr_hi);
      oad_pkg::OAD_IND_LONG:  eff_addr = {ptr_hi, ptr_lo};
      oad_pkg::OAD_IDXIND_S:  eff_addr = add_idx(page0(ptr_hi), index);
      oad_pkg::OAD_IDXIND_L:
        eff_addr = add_idx({ptr_hi, ptr_lo}, index);
      oad_pkg::OAD_REL_DIR:   jump_target = rel(next_pc, opnd_hi);
      oad_pkg::OAD_REL_IND:   jump_target = rel(next_pc, ptr_hi);
      oad_pkg::OAD_BITREL_DIR: begin
        eff_addr    = page0(opnd_hi);
        jump_target = rel(next_pc, opnd_lo);
      end
      oad_pkg::OAD_BITREL_IND: begin
        eff_addr    = page0(ptr_hi);
        jump_target = rel(next_pc, opnd_lo);
      end
      default: ;
    endcase
  end

endmodule

/* verif/oad_decoder_asserts.sv */
`timescale 1ns/100ps
module oad_decoder_asserts (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic [7:0]             index_first,
  input wire logic [7:0]             index_second,
  input wire oad_pkg::oad_op_class_t op_class,
  input wire logic                   wake_irq,
  input wire logic                   mem_req,
  input wire logic                   mem_ack,
  input wire logic                   done,
  input wire oad_pkg::oad_result_t   result,
  input wire logic                   osc_stop,
  input wire logic                   wait_for_interrupt_instr
);
  logic [3:0] acks;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ********************************************************
  // read count per decode
  // ********************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || done) begin
      acks <= 4'h0;
    end else if (mem_req && mem_ack) begin
      acks <= acks + 4'h1;
    end
  end
  chk_req_drop: assert property (
    mem_req && mem_ack |=> !mem_req) else $error("request held");
  chk_done_pulse: assert property (
    done |=> !done) else $error("done too long");
  chk_len_plain: assert property (
    done && result.mode inside {[5'h00:5'h06], 5'h0b, 5'h0d, 5'h0f}
    |-> acks == {1'b0, result.instr_len}) else $error("byte count");
  chk_ptr_byte: assert property (
    done && result.mode inside {5'h07, 5'h09, 5'h0c, 5'h0e, 5'h10}
    |-> acks == {1'b0, result.instr_len} + 4'h1) else $error("ptr byte");
  chk_ptr_word: assert property (
    done && result.mode inside {5'h08, 5'h0a}
    |-> acks == {1'b0, result.instr_len} + 4'h2) else $error("ptr word");
  chk_page_zero: assert property (
    done && result.mode inside {5'h02, 5'h04, 5'h07, [5'h0d:5'h10]}
    |-> result.eff_addr[15:8] == 8'h00) else $error("page zero");
  chk_idx_none: assert property (
    done && result.mode == 5'h04 |-> result.eff_addr == {8'h00,
    result.use_second_idx ? index_second : index_first})
    else $error("index address");
  chk_idx_span: assert property (
    done && result.mode inside {5'h05, 5'h09}
    |-> result.eff_addr <= 16'h01fe) else $error("short index span");
  chk_rmw_long: assert property (
    done |-> result.rmw_long_err == (op_class.is_rmw &&
    result.mode inside {5'h03, 5'h06, 5'h08, 5'h0a}))
    else $error("rmw flag");
  chk_halt_hold: assert property (
    osc_stop && !wake_irq |=> osc_stop) else $error("halt lost");
  chk_wake_clear: assert property (
    wake_irq |=> !osc_stop && !wait_for_interrupt_instr)
    else $error("wake ignored");
endmodule
bind oad_decoder oad_decoder_asserts oad_decoder_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .index_first(index_first),
  .index_second(index_second), .op_class(op_class),
  .wake_irq(wake_irq), .mem_req(mem_req), .mem_ack(mem_ack),
  .done(done), .result(result), .osc_stop(osc_stop),
  .wait_for_interrupt_instr(wait_for_interrupt_instr));

/* verif/oad_mem_model.sv */
`timescale 1ns/100ps
module oad_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic [2:0]  slow,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:65535];
  logic [2:0] wait_cnt;
  // idle data lines toggle so stale bytes never pass
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_cnt <= 3'h0;
      mem_rdata <= 8'h00;
    end else if (!mem_ack && mem_req && wait_cnt == slow) begin
      mem_ack <= 1'b1;
      wait_cnt <= 3'h0;
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_ack <= 1'b0;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 3'h1 : 3'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* verif/test_operand_address_mode_decoder.sv */
`timescale 1ns/100ps
module test_operand_address_mode_decoder;
  typedef struct packed {
    oad_pkg::oad_result_t e;
    logic                 ea;
    logic                 lit;
    logic                 jt;
  } oad_note_t;
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   start = 1'b0;
  logic [15:0]            start_pc = 16'h0000;
  logic [7:0]             index_first = 8'h00;
  logic [7:0]             index_second = 8'h00;
  logic                   wake_irq = 1'b0;
  logic [2:0]             slow = 3'h0;
  logic [31:0]            seed = 32'h00005a7e;
  logic [31:0]            r;
  logic [7:0]             pres [4] = '{8'h00, 8'h90, 8'h92, 8'h00};
  oad_pkg::oad_op_class_t op_class;
  oad_pkg::oad_result_t   result;
  logic [7:0]             mem_rdata;
  logic [7:0]             opcode;
  logic [15:0]            mem_addr;
  logic                   mem_ack;
  logic                   mem_req;
  logic                   busy;
  logic                   done;
  logic                   osc_stop;
  logic                   wait_for_interrupt_instr;
  oad_note_t              notes [$];
  oad_note_t              nt;
  int                     err_total = 0;
  int                     cmp_count = 0;
  // opcode table: mode, rmw, halt, wait, one driver for the whole struct
  assign op_class = {opcode[4:0], opcode[5], opcode[6], opcode[7]};
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  oad_decoder oad_decoder_inst (.ref_clk(ref_clk), .rst(rst),
    .start(start), .start_pc(start_pc), .index_first(index_first),
    .index_second(index_second), .op_class(op_class),
    .wake_irq(wake_irq), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_req(mem_req), .mem_addr(mem_addr), .opcode(opcode),
    .busy(busy), .done(done), .result(result), .osc_stop(osc_stop),
    .wait_for_interrupt_instr(wait_for_interrupt_instr));
  oad_mem_model oad_mem_model_inst (.ref_clk(ref_clk), .rst(rst),
    .mem_req(mem_req), .mem_addr(mem_addr), .slow(slow),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] pz(input logic [7:0] a);
    return oad_mem_model_inst.mem[a];
  endfunction
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic decode(input logic [7:0] pre, input logic [7:0] op,
                        input logic [7:0] b1, input logic [7:0] b2,
                        input logic [7:0] i1, input logic [7:0] i2);
    logic [31:0] x;
    logic [15:0] pc;
    logic [4:0]  md;
    logic [7:0]  ix;
    logic [7:0]  p;
    logic [7:0]  d;
    logic [2:0]  ln;
    int          k;
    oad_note_t   t;
    x = xrand();
    pc = {3'b001, x[12:0]};
    md = op[4:0];
    if (pre == 8'h92) begin
      case (md)
        5'h02, 5'h03: md = md + 5'h05;
        5'h05, 5'h06: md = md + 5'h04;
        5'h0b, 5'h0d, 5'h0f: md = md + 5'h01;
        default: ;
      endcase
    end
    p = b1;
    if (md inside {[5'h07:5'h0a], 5'h0c, 5'h0e, 5'h10}) begin
      p = {1'b0, b1[6:0]};
    end
    k = (pre != 8'h00) ? 1 : 0;
    oad_mem_model_inst.mem[pc] = pre;
    oad_mem_model_inst.mem[pc + 16'(k)] = op;
    oad_mem_model_inst.mem[pc + 16'(k + 1)] = p;
    oad_mem_model_inst.mem[pc + 16'(k + 2)] = b2;
    ln = 3'(k + 1);
    ln = ln + ((md inside {5'h03, 5'h06, 5'h0f, 5'h10}) ? 3'h2 :
              (md inside {5'h00, 5'h04}) ? 3'h0 : 3'h1);
    ix = (pre == 8'h90) ? i2 : i1;
    d = (md == 5'h0b) ? p : (md == 5'h0c) ? pz(p) : b2;
    t = '0;
    t.e.mode = oad_pkg::oad_mode_t'(md);
    t.e.use_second_idx = (pre == 8'h90);
    t.e.instr_len = ln;
    t.e.rmw_long_err = op[5] && (md inside {5'h03, 5'h06, 5'h08, 5'h0a});
    t.e.literal = p;
    t.e.jump_target = pc + 16'(ln) + {{8{d[7]}}, d};
    t.lit = (md == 5'h01);
    t.jt = md inside {5'h0b, 5'h0c, 5'h0f, 5'h10};
    t.ea = !(md inside {5'h00, 5'h01, 5'h0b, 5'h0c});
    case (md)
      5'h02, 5'h0d, 5'h0f: t.e.eff_addr = {8'h00, p};
      5'h03: t.e.eff_addr = {p, b2};
      5'h04: t.e.eff_addr = {8'h00, ix};
      5'h05: t.e.eff_addr = {8'h00, p} + {8'h00, ix};
      5'h06: t.e.eff_addr = {p, b2} + {8'h00, ix};
      5'h07, 5'h0e, 5'h10: t.e.eff_addr = {8'h00, pz(p)};
      5'h08: t.e.eff_addr = {pz(p), pz(p + 8'h01)};
      5'h09: t.e.eff_addr = {8'h00, pz(p)} + {8'h00, ix};
      5'h0a: t.e.eff_addr = {pz(p), pz(p + 8'h01)} + {8'h00, ix};
      default: t.e.eff_addr = 16'h0000;
    endcase
    @(posedge ref_clk);
    start <= 1'b1;
    start_pc <= pc;
    index_first <= i1;
    index_second <= i2;
    slow <= x[15:13];
    notes.push_back(t);
    @(posedge ref_clk);
    start <= 1'b0;
    @(negedge ref_clk);
    check(busy === 1'b1, "not busy after start");
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
    check(k < 200, "no done");
  endtask
  // ********************************************************
  // result monitor
  // ********************************************************
  always @(posedge ref_clk) begin
    if (done === 1'b1) begin
      check(notes.size() != 0, "unexpected done");
      if (notes.size() != 0) begin
        nt = notes.pop_front();
        check(result.mode === nt.e.mode, "mode");
        check(result.instr_len === nt.e.instr_len, "length");
        check(result.use_second_idx === nt.e.use_second_idx, "idx");
        check(result.rmw_long_err === nt.e.rmw_long_err, "rmw");
        check(!nt.ea || result.eff_addr === nt.e.eff_addr, "addr");
        check(!nt.lit || result.literal === nt.e.literal, "lit");
        check(!nt.jt || result.jump_target === nt.e.jump_target,
              "jr");
      end
    end
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
  // ********************************************************
  // scenarios
  // ********************************************************
  initial begin
    for (int i = 0; i < 256; i++) begin
      r = xrand();
      oad_mem_model_inst.mem[i] = r[7:0];
    end
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      for (int m = 0; m < 17; m++) begin
        r = xrand();
        decode(pres[j], {2'b00, r[24], 5'(m)}, r[7:0], r[15:8], r[23:16],
               r[31:24]);
      end
    end
    decode(8'h00, 8'h05, 8'hff, 8'h00, 8'hff, 8'h00);
    decode(8'h90, 8'h06, 8'hff, 8'h00, 8'h00, 8'hff);
    decode(8'h00, 8'h0b, 8'h80, 8'h00, 8'h00, 8'h00);
    decode(8'h92, 8'h0f, 8'h05, 8'h7f, 8'h00, 8'h00);
    for (int j = 0; j < 2; j++) begin
      decode(8'h00, j ? 8'h80 : 8'h40, 8'h00, 8'h00, 8'h00, 8'h00);
      check((j ? wait_for_interrupt_instr : osc_stop) === 1'b1,
            "no low power");
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      @(negedge ref_clk);
      check(busy === 1'b0, "start taken while asleep");
      @(posedge ref_clk);
      wake_irq <= 1'b1;
      @(posedge ref_clk);
      wake_irq <= 1'b0;
      @(negedge ref_clk);
      check(!osc_stop && !wait_for_interrupt_instr, "no wake");
    end
    for (int n = 0; n < 120; n++) begin
      r = xrand();
      decode(pres[r[26:25]], {2'b00, r[24], (r[4:0] > 5'h10) ?
             r[4:0] - 5'h10 : r[4:0]}, r[15:8], r[23:16], r[31:24],
             r[7:0]);
    end
    print_verdict();
  end
endmodule
